/* File: l2_control_cfg.svh */
// constants for the l2 system control register
`ifndef L2_CONTROL_CFG_SVH
`define L2_CONTROL_CFG_SVH
`define L2C_VALID_RAM_INHIBIT_BIT 31
`define L2C_CORE_COUNT_MSB        25
`define L2C_CORE_COUNT_LSB        24
`define L2C_INTC_PRESENT_BIT      23
`define L2C_ECC_ENABLE_BIT        21
`define L2C_TAG_SLICE_BIT         12
`define L2C_ECC_ENABLE_RESET      1'h0
`define L2C_RDATA_RESET           32'h0000_0000
`endif

/* File: l2_control_pkg.sv */
// types for the l2 system control register
`default_nettype none
package l2_control_pkg;
  typedef enum logic [1:0] {
    mode_user,
    mode_pl1_secure,
    mode_pl1_nonsecure,
    mode_pl2
  } access_mode_t;

  typedef enum logic [1:0] {
    answer_ok_read,
    answer_ok_write,
    answer_ignored_write,
    answer_denied
  } access_answer_t;
endpackage : l2_control_pkg
`default_nettype wire

/* File: l2_access_if.sv */
// carries the permission decision between the check and the register
`default_nettype none
interface l2_access_if;
  logic read_ok;
  logic write_ok;
  logic write_ignored;
  logic denied;
  modport checker_side (output read_ok, output write_ok, output write_ignored, output denied);
  modport register_side (input read_ok, input write_ok, input write_ignored, input denied);
endinterface : l2_access_if
`default_nettype wire

/* File: l2_access_check.sv */
// privilege and security check for register accesses
`default_nettype none
module l2_access_check (
  // request
  input  wire logic                         read_in,
  input  wire logic                         write_in,
  input  wire l2_control_pkg::access_mode_t mode_in,
  // decision
  l2_access_if.checker_side                 acc
);
  logic any_req;
  assign any_req = read_in | write_in;

  always_comb begin
    acc.read_ok       = 1'b0;
    acc.write_ok      = 1'b0;
    acc.write_ignored = 1'b0;
    acc.denied        = 1'b0;
    unique case (mode_in)
      l2_control_pkg::mode_user: begin
        acc.denied = any_req;
      end
      l2_control_pkg::mode_pl1_secure: begin
        acc.read_ok  = read_in;
        acc.write_ok = write_in & ~read_in;
      end
      l2_control_pkg::mode_pl1_nonsecure,
      l2_control_pkg::mode_pl2: begin
        acc.read_ok       = read_in;
        acc.write_ignored = write_in & ~read_in;
      end
    endcase
  end
endmodule : l2_access_check
`default_nettype wire

/* File: l2_memory_control_register.sv */
// l2 system control register with configuration status and ecc enable
// Notes on behaviour
// - bit 31 mirrors the valid-ram reset-inhibit pin and is read-only.
// - bits 25:24 give the core count minus one from the configuration, read-only.
// - bit 23 reads 1 when an interrupt controller is configured, read-only.
// - bit 21 enables ecc and parity in l1 and l2 caches and resets to 0.
// - without configured ecc/parity bit 21 reads zero and writes to it are ignored.
// - bit 12 reads the tag ram slice count from the configuration, read-only.
// - one copy of the register serves both security states.
// - accesses from below privilege level one are denied.
// - secure level-one modes read and write, non-secure level-one and level-two modes read only.
`include "l2_control_cfg.svh"
`default_nettype none
module l2_memory_control_register #(
  parameter int unsigned CORE_COUNT     = 4,
  parameter bit          HAS_INTC       = 1'b1,
  parameter bit          HAS_ECC        = 1'b1,
  parameter int unsigned TAG_RAM_SLICES = 0
) (
  // clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         arst_n_in,
  // pins
  input  wire logic                         valid_ram_reset_inhibit_pin_in,
  // register access port
  input  wire logic                         read_in,
  input  wire logic                         write_in,
  input  wire l2_control_pkg::access_mode_t mode_in,
  input  wire logic [31:0]                  wdata_in,
  output logic [31:0]                       rdata_out,
  output logic                              rvalid_out,
  output logic                              wdone_out,
  output logic                              denied_out,
  // control towards the caches
  output logic                              ecc_enable_out
);
  // refuse configurations the two-bit and one-bit fields cannot show
  if (CORE_COUNT < 1 || CORE_COUNT > 4) begin : g_bad_core_count
    $error("CORE_COUNT must be 1 to 4");
  end
  if (TAG_RAM_SLICES > 1) begin : g_bad_tag_slices
    $error("TAG_RAM_SLICES must be 0 or 1");
  end

  localparam logic [1:0] CORE_FIELD = 2'(CORE_COUNT - 1);
  localparam logic       TAG_FIELD  = 1'(TAG_RAM_SLICES);

  l2_access_if acc ();

  l2_access_check u_check (
    .read_in  (read_in),
    .write_in (write_in),
    .mode_in  (mode_in),
    .acc      (acc.checker_side)
  );

  // single unbanked copy
  logic        ecc_enable;
  logic        inhibit_mirror;
  logic [31:0] next_rdata;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ecc_enable <= `L2C_ECC_ENABLE_RESET;
    end else if (acc.write_ok && HAS_ECC) begin
      ecc_enable <= wdata_in[`L2C_ECC_ENABLE_BIT];
    end
  end

  // pin taken each cycle so the mirror tracks it
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      inhibit_mirror <= 1'b0;
    end else begin
      inhibit_mirror <= valid_ram_reset_inhibit_pin_in;
    end
  end

  always_comb begin
    next_rdata                                           = `L2C_RDATA_RESET;
    next_rdata[`L2C_VALID_RAM_INHIBIT_BIT]               = inhibit_mirror;
    next_rdata[`L2C_CORE_COUNT_MSB:`L2C_CORE_COUNT_LSB]  = CORE_FIELD;
    next_rdata[`L2C_INTC_PRESENT_BIT]                    = HAS_INTC;
    next_rdata[`L2C_ECC_ENABLE_BIT]                      = ecc_enable & HAS_ECC;
    next_rdata[`L2C_TAG_SLICE_BIT]                       = TAG_FIELD;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out  <= `L2C_RDATA_RESET;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= acc.read_ok;
      rdata_out  <= acc.read_ok ? next_rdata : `L2C_RDATA_RESET;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wdone_out  <= 1'b0;
      denied_out <= 1'b0;
    end else begin
      wdone_out  <= acc.write_ok | acc.write_ignored;
      denied_out <= acc.denied;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ecc_enable_out <= `L2C_ECC_ENABLE_RESET;
    end else begin
      ecc_enable_out <= ecc_enable & HAS_ECC;
    end
  end
endmodule : l2_memory_control_register
`default_nettype wire

/* File: l2_control_properties.sv */
// assertions on the ports of the l2 system control register
`default_nettype none
module l2_control_properties #(
  parameter bit HAS_ECC = 1'b1
) (
  input wire logic        clk_in, arst_n_in, valid_ram_reset_inhibit_pin_in, read_in, write_in,
  input wire l2_control_pkg::access_mode_t mode_in,
  input wire logic [31:0] wdata_in, rdata_out,
  input wire logic        rvalid_out, wdone_out, denied_out, ecc_enable_out
);
  wire logic usr = mode_in == l2_control_pkg::mode_user;
  wire logic sec = mode_in == l2_control_pkg::mode_pl1_secure;
  wire logic sec_write = write_in && !read_in && sec;
  wire logic wbit = wdata_in[21];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence keep(ack);
    ack ##1 ($stable(ecc_enable_out) || $past(sec_write));
  endsequence
  a_user_denied: assert property ((read_in || write_in) && usr |=> denied_out && rdata_out == 32'h0)
    else $error("user access answered");
  a_user_write_kept: assert property (write_in && !read_in && usr |=> keep(!wdone_out))
    else $error("user write took effect");
  a_fixed_fields: assert property (read_in && !usr |=> rvalid_out && rdata_out[25:23] == 3'h7
    && (rdata_out & 32'h7c5f_ffff) == 32'h0) else $error("fixed fields wrong");
  a_pin_mirror: assert property (read_in && !usr && $past(arst_n_in) && $stable(valid_ram_reset_inhibit_pin_in)
    |=> rdata_out[31] == $past(valid_ram_reset_inhibit_pin_in)) else $error("pin mirror wrong");
  a_ecc_readback: assert property (rvalid_out && !$past(wdone_out) |-> rdata_out[21] == ecc_enable_out)
    else $error("ecc bit read wrong");
  a_secure_write: assert property (sec_write |=> wdone_out ##1 ecc_enable_out == (HAS_ECC & $past(wbit, 2)))
    else $error("secure write lost");
  a_ns_write_ignored: assert property (write_in && !read_in && !sec && !usr |=> keep(wdone_out))
    else $error("write not ignored");
  a_idle_quiet: assert property (!read_in && !write_in |=> !(rvalid_out || wdone_out || denied_out))
    else $error("answer without request");
endmodule : l2_control_properties
bind l2_memory_control_register l2_control_properties #(.HAS_ECC(HAS_ECC)) chk (.*);
`default_nettype wire

/* File: tb_l2_memory_control_register.sv */
// random self-checking bench for the l2 system control register
`default_nettype none
module tb_l2_memory_control_register;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0, arst_n_in = 1'b0, valid_ram_reset_inhibit_pin_in = 1'b0, read_in = 1'b0, write_in = 1'b0;
  logic [1:0]  md = 2'h0;
  logic [31:0] wdata_in = 32'h0;
  logic [31:0] rdata_out;
  logic        rvalid_out, wdone_out, denied_out, ecc_enable_out;
  int          fails = 0;
  int          num_checks = 0;
  int          seed = 83050;
  logic [31:0] rdata_b;
  logic        rvalid_b, wdone_b, denied_b, ecc_b;
  l2_memory_control_register dut (.mode_in(l2_control_pkg::access_mode_t'(md)), .*);
  // second copy built without ecc support
  l2_memory_control_register #(.HAS_ECC(1'b0)) dut_no_ecc (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .valid_ram_reset_inhibit_pin_in(valid_ram_reset_inhibit_pin_in),
    .read_in(read_in), .write_in(write_in), .mode_in(l2_control_pkg::access_mode_t'(md)), .wdata_in(wdata_in),
    .rdata_out(rdata_b), .rvalid_out(rvalid_b), .wdone_out(wdone_b), .denied_out(denied_b), .ecc_enable_out(ecc_b));
  function automatic logic [34:0] answer(logic [1:0] k, logic [1:0] m, logic p, logic e);
    if (k != 2'h0 && m == 2'h0) return {3'h1, 32'h0};
    if (k[0]) return {3'h4, p, 7'h3, 2'h2, e, 21'h0};
    return {1'b0, k[1], 33'h0};
  endfunction : answer
  task automatic check(string what, logic [34:0] seen, logic [34:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  initial forever #2 clk_in = ~clk_in;
  initial begin
    #10000;
    fails++;
    report_and_stop();
  end
  initial begin
    logic [1:0] k;
    logic       p, ecc;
    ecc = 1'b0;
    repeat (12) @(posedge clk_in);
    arst_n_in <= 1'b1;
    // first three: secure set, then user and level-two writes of zero
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_in);
      k = (i < 3) ? 2'h2 : 2'($random(seed));
      md <= (i < 3) ? 2'(i * 3 + 1) : 2'($random(seed));
      wdata_in <= (i < 3) ? {32{i == 0}} : $random(seed);
      read_in <= k[0];
      write_in <= k[1];
      @(posedge clk_in);
      p = valid_ram_reset_inhibit_pin_in;
      read_in <= 1'b0;
      write_in <= 1'b0;
      valid_ram_reset_inhibit_pin_in <= 1'($random(seed));
      #1;
      check("ecc_enable_out", 35'(ecc_enable_out), 35'(ecc));
      check("answer", {rvalid_out, wdone_out, denied_out, rdata_out}, answer(k, md, p, ecc));
      check("no_ecc enable", 35'(ecc_b), 35'h0);
      check("no_ecc answer", {rvalid_b, wdone_b, denied_b, rdata_b}, answer(k, md, p, 1'b0));
      if (k == 2'h2 && md == 2'h1) ecc = wdata_in[21];
    end
    report_and_stop();
  end
endmodule : tb_l2_memory_control_register
`default_nettype wire
